/* hw/ret_pkg.sv */
// Constants for the elapsed-time timer: register map, field layout, reset values.
// Assumes a 32-bit word register port; offsets are byte addresses.
package ret_pkg;
    localparam int          REG_ADDR_W       = 4;
    localparam int          DATA_W           = 32;
    localparam int          PRESCALE_W       = 16;

    // Register offsets
    localparam logic [3:0]  OFS_MODE         = 4'h0;
    localparam logic [3:0]  OFS_ALARM        = 4'h4;
    localparam logic [3:0]  OFS_COUNT        = 4'h8;
    localparam logic [3:0]  OFS_STATUS       = 4'hc;

    // Mode register fields
    localparam int          MODE_PRES_LSB    = 0;
    localparam int          MODE_ALM_IEN     = 16;
    localparam int          MODE_WRAP_IEN    = 17;
    localparam int          MODE_RESTART     = 18;
    localparam int          MODE_OFF         = 20;
    localparam int          MODE_EXT_SEL     = 24;

    // Status register fields
    localparam int          STAT_ALARM       = 0;
    localparam int          STAT_WRAP        = 1;

    // Reset values and step constants
    localparam logic [15:0] PRESCALE_RST     = 16'h8000;
    localparam logic [31:0] ALARM_RST        = 32'hffff_ffff;
    localparam logic [31:0] COUNT_RST        = 32'h0000_0000;
    localparam logic [15:0] PRES_CNT_RST     = 16'h0000;
    localparam logic [15:0] PRES_STEP        = 16'h0001;
    localparam logic [31:0] COUNT_STEP       = 32'h0000_0001;
    localparam logic [31:0] WORD_ZERO        = 32'h0000_0000;
endpackage

/* hw/ret_prescaler.sv */
// Programmable divider stepped once per slow-clock tick.
// Assumes tick is a one-cycle pulse in the clk domain.
module ret_prescaler #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Control
    input  wire logic             tick,
    input  wire logic             run,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] period,
    // Event
    output logic                  wrap
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic [WIDTH-1:0] last;
    logic             at_last;

    // period zero wraps after full range
    assign last    = period - WIDTH'(1);
    assign at_last = (cnt_q == last);
    assign cnt_d   = restart          ? '0 :
                     !(tick && run)   ? cnt_q :
                     at_last          ? '0 : cnt_q + WIDTH'(1);
    assign wrap    = tick && run && !restart && at_last;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule

/* hw/ret_timer.sv */
// Elapsed-time timer: prescaler, 32-bit counter, alarm compare, status and interrupt.
// Assumes slow_clock and second_tick are level inputs synchronous to clk.
//
// Contract
// - With external select 0, each prescaler wrap adds one to the counter.
// - Prescaler period equals programmed value; zero means 65536 slow periods.
// - Prescale value resets to 0x8000, one count per second.
// - Counter runs freely and wraps to zero after its maximum.
// - Every prescaler wrap sets the wrap flag, counted or not.
// - With external select 1, counter steps on each external second tick.
// - Counter stepping from the alarm value sets the alarm flag.
// - Alarm register resets to all ones.
// - Alarm flag always drives the alarm output.
// - Status read clears wrap and alarm flags.
// - Interrupt follows flags two slow-clock cycles later.
// - Restart reloads prescaler and clears counter to zero.
// - Off control stops the timer.
// - Alarm interrupt enable gates alarm flag onto interrupt.
// - Wrap interrupt enable gates wrap flag onto interrupt.
// - Off control and external select read back as zero.
// - When alarm flag rises counter already holds alarm plus one.
module ret_timer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Time bases
    input  wire logic        slow_clock,
    input  wire logic        second_tick,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // Events
    output logic             irq,
    output logic             alarm
);
    // Reset release
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Register state
    logic [15:0] prescale_value_q;
    logic        alarm_irq_enable_q;
    logic        wrap_irq_enable_q;
    logic        timer_off_control_q;
    logic        external_second_select_q;
    logic [31:0] alarm_value_q;
    logic [31:0] current_count_q;
    logic [31:0] current_count_d;
    logic        alarm_hit_flag_q;
    logic        prescaler_wrap_flag_q;
    logic        slow_q;
    logic        second_q;
    logic        irq_stage_q;
    logic        irq_q;
    logic [31:0] rdata_q;

    // Address match shared by strobes and read mux
    function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // Decode
    logic wr_mode;
    logic wr_alarm;
    logic rd_status;
    logic divider_restart;
    assign wr_mode         = wr && reg_hit(addr, ret_pkg::OFS_MODE);
    assign wr_alarm        = wr && reg_hit(addr, ret_pkg::OFS_ALARM);
    assign rd_status       = rd && reg_hit(addr, ret_pkg::OFS_STATUS);
    // restart is a write pulse, never stored
    assign divider_restart = wr_mode && wdata[ret_pkg::MODE_RESTART];

    // Time-base edges; inputs already in clk domain
    logic slow_tick;
    logic ext_tick;
    logic running;
    assign slow_tick = slow_clock && !slow_q;
    assign ext_tick  = second_tick && !second_q;
    assign running   = !timer_off_control_q;

    logic wrap_evt;
    ret_prescaler #(
        .WIDTH   (ret_pkg::PRESCALE_W)
    ) u_pres (
        .clk     (clk),
        .rst_n   (rst_n),
        .tick    (slow_tick),
        .run     (running),
        .restart (divider_restart),
        .period  (prescale_value_q),
        .wrap    (wrap_evt)
    );

    // Counter step source
    logic step;
    logic alarm_evt;
    assign step = running && (external_second_select_q ? ext_tick : wrap_evt);
    // compare at the step so flag rises with count = alarm + 1
    assign alarm_evt = step && !divider_restart && (current_count_q == alarm_value_q);
    assign current_count_d = divider_restart ? ret_pkg::COUNT_RST :
                             step            ? current_count_q + ret_pkg::COUNT_STEP :
                                               current_count_q;

    // Masked interrupt request
    logic irq_src;
    assign irq_src = (alarm_irq_enable_q && alarm_hit_flag_q)
                   || (wrap_irq_enable_q && prescaler_wrap_flag_q);

    // Read mux
    logic [31:0] mode_rd;
    logic [31:0] status_rd;
    logic [31:0] rd_mux;
    always_comb begin
        mode_rd = ret_pkg::WORD_ZERO;
        mode_rd[ret_pkg::MODE_PRES_LSB +: ret_pkg::PRESCALE_W] = prescale_value_q;
        mode_rd[ret_pkg::MODE_ALM_IEN]  = alarm_irq_enable_q;
        mode_rd[ret_pkg::MODE_WRAP_IEN] = wrap_irq_enable_q;
        // off and select bits read as zero
        status_rd = ret_pkg::WORD_ZERO;
        status_rd[ret_pkg::STAT_ALARM] = alarm_hit_flag_q;
        status_rd[ret_pkg::STAT_WRAP]  = prescaler_wrap_flag_q;
    end
    // Unmapped offsets read as zero
    assign rd_mux = reg_hit(addr, ret_pkg::OFS_MODE)   ? mode_rd :
                    reg_hit(addr, ret_pkg::OFS_ALARM)  ? alarm_value_q :
                    reg_hit(addr, ret_pkg::OFS_COUNT)  ? current_count_q :
                    reg_hit(addr, ret_pkg::OFS_STATUS) ? status_rd : ret_pkg::WORD_ZERO;

    // Mode register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // one second per count at reset
            prescale_value_q         <= ret_pkg::PRESCALE_RST;
            alarm_irq_enable_q       <= 1'b0;
            wrap_irq_enable_q        <= 1'b0;
            timer_off_control_q      <= 1'b0;
            external_second_select_q <= 1'b0;
        end else if (wr_mode) begin
            prescale_value_q         <= wdata[ret_pkg::MODE_PRES_LSB +: ret_pkg::PRESCALE_W];
            alarm_irq_enable_q       <= wdata[ret_pkg::MODE_ALM_IEN];
            wrap_irq_enable_q        <= wdata[ret_pkg::MODE_WRAP_IEN];
            timer_off_control_q      <= wdata[ret_pkg::MODE_OFF];
            external_second_select_q <= wdata[ret_pkg::MODE_EXT_SEL];
        end
    end

    // Alarm register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_value_q <= ret_pkg::ALARM_RST;
        end else if (wr_alarm) begin
            alarm_value_q <= wdata;
        end
    end

    // Counter and edge history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            current_count_q <= ret_pkg::COUNT_RST;
            slow_q          <= 1'b0;
            second_q        <= 1'b0;
        end else begin
            current_count_q <= current_count_d;
            slow_q          <= slow_clock;
            second_q        <= second_tick;
        end
    end

    // Status flags; a new event in the read cycle survives the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_hit_flag_q      <= 1'b0;
            prescaler_wrap_flag_q <= 1'b0;
        end else begin
            // cleared on status read, set wins
            prescaler_wrap_flag_q <= (wrap_evt) || (prescaler_wrap_flag_q && !rd_status);
            alarm_hit_flag_q      <= alarm_evt || (alarm_hit_flag_q && !rd_status);
        end
    end

    // interrupt retimed over two slow-clock edges; runs even when off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stage_q <= 1'b0;
            irq_q       <= 1'b0;
        end else if (slow_tick) begin
            irq_stage_q <= irq_src;
            irq_q       <= irq_stage_q;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= ret_pkg::WORD_ZERO;
        end else begin
            rdata_q <= rd ? rd_mux : ret_pkg::WORD_ZERO;
        end
    end

    // alarm output is the flag itself
    assign alarm = alarm_hit_flag_q;
    assign irq   = irq_q;
    assign rdata = rdata_q;
endmodule

/* test/ret_timer_checker.sv */
// Port-level checker for ret_timer: readback, status clear, irq mask, restart, off.
// Assumes it is bound to ret_timer and sees only that module's ports.
module ret_timer_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Stimulus side
    input wire logic        slow_clock,
    input wire logic [3:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    // Design outputs
    input wire logic [31:0] rdata,
    input wire logic        irq,
    input wire logic        alarm
);
    logic [17:0] mode_q;
    logic [31:0] alm_q;
    logic        off_q;
    logic        sl_q;
    logic [1:0]  tk_q;
    wire         mode_wr = wr && addr == 4'h0;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Software-visible copy of written settings; tick count since last mode write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q <= 18'h0_8000;
            alm_q  <= 32'hffff_ffff;
            off_q  <= 1'b0;
            sl_q   <= 1'b0;
            tk_q   <= 2'h3;
        end else begin
            sl_q <= slow_clock;
            if (mode_wr) begin
                mode_q <= {wdata[17:16], wdata[15:0]};
                off_q  <= wdata[20];
                tk_q   <= 2'h0;
            end else if (slow_clock && !sl_q && tk_q != 2'h3) begin
                tk_q <= tk_q + 2'h1;
            end
            if (wr && addr == 4'h4) begin
                alm_q <= wdata;
            end
        end
    end

    rst_quiet_a: assert property ($rose(rstn) |-> (rdata == 32'h0000_0000 && !irq && !alarm)[*2])
        else $error("outputs not quiet after reset");
    mode_rd_a: assert property ($past(rd) && $past(addr) == 4'h0 |-> rdata == {14'h0, mode_q})
        else $error("mode readback wrong");
    alarm_rd_a: assert property ($past(rd) && $past(addr) == 4'h4 |-> rdata == alm_q)
        else $error("alarm readback wrong");
    stat_bits_a: assert property ($past(rd) && $past(addr) == 4'hc |-> rdata[31:2] == 30'h0)
        else $error("status reserved bits set");
    stat_clr_a: assert property (rd && addr == 4'hc ##1 rdata[0] |-> ##1 !alarm)
        else $error("alarm not cleared by status read");
    irq_mask_a: assert property (mode_q[17:16] == 2'h0 && tk_q == 2'h3 |-> !irq)
        else $error("irq high with both enables off");
    restart_clr_a: assert property (mode_wr && wdata[18] && !wdata[20] ##[1:2] rd && addr == 4'h8
        |-> ##1 rdata == 32'h0000_0000)
        else $error("count not cleared by restart");
    off_hold_a: assert property ($rose(alarm) |-> !($past(off_q) && $past(off_q, 2) && $past(off_q, 3)))
        else $error("alarm rose while timer off");

    cover property ($rose(irq));
    cover property ($rose(alarm));
    cover property ($past(rd) && $past(addr) == 4'hc && rdata[1]);
endmodule

bind ret_timer ret_timer_checker u_chk (.clk(clk), .rstn(rstn), .slow_clock(slow_clock),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .alarm(alarm));

/* test/tb_top.sv */
// Self-checking bench for ret_timer: register port, scaled slow clock, second tick.
// Assumes the 40 ns clock; one slow tick every four clocks keeps the run short.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk         = 1'b0;
    logic        rstn        = 1'b0;
    logic        slow_clock  = 1'b0;
    logic        second_tick = 1'b0;
    logic [3:0]  addr        = 4'h0;
    logic [31:0] wdata       = 32'h0000_0000;
    logic        wr          = 1'b0;
    logic        rd          = 1'b0;
    logic [1:0]  div_q       = 2'h0;
    logic [31:0] rdata;
    logic        irq;
    logic        alarm;
    logic [31:0] v;
    int          fails       = 0;
    int          tests_run   = 0;

    ret_timer u_dut (.clk(clk), .rstn(rstn), .slow_clock(slow_clock), .second_tick(second_tick),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .alarm(alarm));

    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        div_q      <= div_q + 2'h1;
        slow_clock <= div_q[1];
    end

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One strobe cycle, then release; read data land in v
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), v, e);
    endtask

    task automatic ticks(input int n);
        repeat (n * 4) @(posedge clk);
    endtask

    task automatic t_reset();
        rchk(4'h0, 32'h0000_8000);
        rchk(4'h4, 32'hffff_ffff);
        rchk(4'h8, 32'h0000_0000);
        rchk(4'hc, 32'h0000_0000);
    endtask

    task automatic t_count();
        bus(1'b1, 4'h0, 32'h0004_0003);
        ticks(16);
        rchk(4'h8, 32'h0000_0005);
        rchk(4'hc, 32'h0000_0002);
        rchk(4'h0, 32'h0000_0003);
    endtask

    // Prescaler would give two steps here; the tick must give three
    task automatic t_ext();
        bus(1'b1, 4'h0, 32'h0104_0003);
        repeat (3) begin
            @(posedge clk);
            second_tick <= 1'b1;
            ticks(1);
            second_tick <= 1'b0;
            ticks(1);
        end
        rchk(4'h8, 32'h0000_0003);
        rchk(4'h0, 32'h0000_0003);
    endtask

    task automatic t_wrap_off();
        bus(1'b1, 4'h0, 32'h0006_0003);
        ticks(8);
        #1;
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        bus(1'b1, 4'h0, 32'h0010_0003);
        rchk(4'hc, 32'h0000_0002);
        rchk(4'h0, 32'h0000_0003);
        bus(1'b0, 4'h8, 32'h0000_0000);
        rchk(4'h8, v);
        ticks(12);
        rchk(4'h8, v);
        rchk(4'hc, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic t_alarm();
        bus(1'b1, 4'h4, 32'h0000_0002);
        bus(1'b1, 4'h0, 32'h0005_0003);
        // Sample a step after the edge so the new flag value is seen
        repeat (200) begin
            if (alarm !== 1'b1) begin
                @(posedge clk);
                #1;
            end
        end
        chk("alarm", {31'h0, alarm}, 32'h0000_0001);
        rchk(4'h8, 32'h0000_0003);
        ticks(3);
        #1;
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        rchk(4'hc, 32'h0000_0003);
        chk("alarm", {31'h0, alarm}, 32'h0000_0000);
        ticks(3);
        #1;
        chk("irq", {31'h0, irq}, 32'h0000_0000);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_count();
        t_ext();
        t_wrap_off();
        t_alarm();
        tally_and_finish();
    end

    // Whole sequence needs well under a thousand clocks
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule
